// File: tab_proto.sv
// Purpose: Block protocol handler and command decoder for a contactless tag
// Assumes: Received bytes arrive framed, CRC bytes included, from a same-clock decoder
// Notes: Response bytes leave through a two-entry buffer, last byte flagged
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Answer only after a received command
// - Classify blocks as I, R or S
// - Class 0x00 standard, 0xA2 proprietary
// - Standard 0xA4 decodes as select
// - Standard 0xD6 decodes as update
// - Standard 0x20 decodes as verify
// - Standard 0x24 decodes as change password
// - Standard 0x28 enables password protection
// - Standard 0x26 disables password protection
// - Proprietary 0x28 decodes as permanent lock
// - PCB, optional DID, 1-251 payload, CRC
// - I-block PCB fixed bits checked
// - Tag block number starts at 1
// - Toggle block number on received I-block
// - Non-compliant numbering ignored, no response
// - ACK with differing number toggles
// - NAK never changes block number
// - Payload is CLA INS P1 P2 Lc data Le
// - Commands in, responses out
// - CRC reflected 13239, init 0x6363, uninverted
// - Success response ends 0x90 0x00
module tab_proto (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Activation, restarts the block numbering
  input wire logic activate_i,
  // Received frame bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  // Decoded command
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [7:0] cmd_p1_o,
  output logic [7:0] cmd_p2_o,
  output logic [7:0] cmd_lc_o,
  output logic [7:0] cmd_le_o,
  output logic deselect_o,
  output logic block_num_o,
  // Response payload bytes, CRC appended downstream
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_last_o
);
  import tab_pkg::*;

  typedef enum {ST_IDLE, ST_PCB, ST_ACK, ST_SW1, ST_SW2} tab_tx_e;

  logic [15:0] crc;
  logic [15:0] next_crc;
  logic [7:0] pos;
  logic [7:0] next_pos;
  logic [7:0] pcb;
  logic [7:0] next_pcb;
  logic [7:0] cla;
  logic [7:0] next_cla;
  logic [7:0] ins;
  logic [7:0] next_ins;
  logic [7:0] p1;
  logic [7:0] next_p1;
  logic [7:0] p2;
  logic [7:0] next_p2;
  logic [7:0] lc;
  logic [7:0] next_lc;
  logic [7:0] le;
  logic [7:0] next_le;
  logic in_frame;
  logic next_in_frame;
  logic bn;
  logic next_bn;
  logic cmd_valid;
  logic next_cmd_valid;
  logic [3:0] cmd_code;
  logic [3:0] next_cmd_code;
  logic desel;
  logic next_desel;
  tab_tx_e tx_st;
  tab_tx_e next_tx_st;
  logic [7:0] hdr_len;
  logic [7:0] pay_len;
  logic [1:0] blk;
  logic crc_ok;
  logic push;
  logic [8:0] push_data;
  logic buf_ready;
  logic buf_valid;
  logic [8:0] buf_data;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REF) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
  function automatic logic [3:0] decode(input logic [7:0] c, input logic [7:0] n);
    logic [3:0] k;
    k = CMD_UNKNOWN;
    if (c == CLA_STD) begin
      case (n)
        INS_SELECT: k = CMD_SELECT;
        INS_READ: k = CMD_READ;
        INS_UPDATE: k = CMD_UPDATE;
        INS_VERIFY: k = CMD_VERIFY;
        INS_CHG_REF: k = CMD_CHG_REF;
        INS_EN_VER: k = CMD_EN_VER;
        INS_DIS_VER: k = CMD_DIS_VER;
        default: k = CMD_UNKNOWN;
      endcase
    end else if (c == CLA_PROP) begin
      case (n)
        INS_EN_VER: k = CMD_PERM_LOCK;
        INS_READ: k = CMD_EXT_READ;
        default: k = CMD_UNKNOWN;
      endcase
    end
    return k;
  endfunction : decode
  always_comb begin
    if ((pcb & I_MASK) == I_VAL) begin
      blk = BLK_I;
    end else if ((pcb & R_MASK) == R_VAL) begin
      blk = BLK_R;
    end else if ((pcb & S_MASK) == S_VAL) begin
      blk = BLK_S;
    end else begin
      blk = BLK_BAD;
    end
  end
  // Receive path
  always_comb begin
    hdr_len = pcb[PCB_DID] ? 8'h02 : 8'h01;
    pay_len = pos - hdr_len - 8'h02;
    crc_ok = (crc == CRC_RESIDUE);
    next_crc = crc;
    next_pos = pos;
    next_pcb = pcb;
    next_cla = cla;
    next_ins = ins;
    next_p1 = p1;
    next_p2 = p2;
    next_lc = lc;
    next_le = le;
    next_in_frame = in_frame;
    next_bn = bn;
    next_cmd_valid = 1'b0;
    next_cmd_code = cmd_code;
    next_desel = 1'b0;
    if (rx_valid_i) begin
      if (rx_sof_i) begin
        next_crc = crc_byte(CRC_INIT, rx_data_i);
        next_pcb = rx_data_i;
        next_pos = 8'h01;
        next_in_frame = 1'b1;
      end else if (in_frame) begin
        next_crc = crc_byte(crc, rx_data_i);
        if (pos != 8'hff) begin
          next_pos = pos + 8'h01;
        end
        case (pos - hdr_len)
          8'h00: next_cla = rx_data_i;
          8'h01: next_ins = rx_data_i;
          8'h02: next_p1 = rx_data_i;
          8'h03: next_p2 = rx_data_i;
          8'h04: next_lc = rx_data_i;
          default: next_lc = lc;
        endcase
        // Le follows the Lc data bytes
        if ((pos - hdr_len) == (HDR_LEN + lc)) begin
          next_le = rx_data_i;
        end
      end
    end
    if (in_frame && !rx_valid_i && rx_eof_i) begin
      next_in_frame = 1'b0;
      // drop bad CRC or bad PCB
      if (crc_ok && pos > hdr_len + 8'h02 && tx_st == ST_IDLE) begin
        if (blk == BLK_I && pay_len >= 8'h01 && pay_len <= MAX_PAYLOAD && pcb[PCB_BN] != bn) begin
          next_bn = ~bn;
          next_cmd_valid = 1'b1;
          next_cmd_code = (pay_len >= HDR_LEN) ? decode(cla, ins) : CMD_UNKNOWN;
        end
      end else if (crc_ok && pos == hdr_len + 8'h02 && tx_st == ST_IDLE) begin
        if (blk == BLK_R && !pcb[PCB_ACK] && pcb[PCB_BN] != bn) begin
          next_bn = ~bn;
        end
        if (blk == BLK_S && !pcb[PCB_WTX]) begin
          next_desel = 1'b1;
        end
      end
    end
    // number starts at 1 on activation
    if (activate_i) begin
      next_bn = 1'b1;
      next_in_frame = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc <= CRC_INIT;
      pos <= 8'h00;
      pcb <= 8'h00;
      cla <= 8'h00;
      ins <= 8'h00;
      p1 <= 8'h00;
      p2 <= 8'h00;
      lc <= 8'h00;
      le <= 8'h00;
      in_frame <= 1'b0;
      bn <= 1'b1;
      cmd_valid <= 1'b0;
      cmd_code <= CMD_NONE;
      desel <= 1'b0;
    end else begin
      crc <= next_crc;
      pos <= next_pos;
      pcb <= next_pcb;
      cla <= next_cla;
      ins <= next_ins;
      p1 <= next_p1;
      p2 <= next_p2;
      lc <= next_lc;
      le <= next_le;
      in_frame <= next_in_frame;
      bn <= next_bn;
      cmd_valid <= next_cmd_valid;
      cmd_code <= next_cmd_code;
      desel <= next_desel;
    end
  end

  // Response path
  always_comb begin
    next_tx_st = tx_st;
    push = 1'b0;
    push_data = 9'h000;
    case (tx_st)
      ST_IDLE: begin
        // respond only to a taken command
        if (cmd_valid) begin
          next_tx_st = ST_PCB;
        end
      end
      ST_PCB: begin
        push = 1'b1;
        push_data = {1'b0, I_VAL | {7'h00, bn}};
        if (buf_ready) begin
          next_tx_st = ST_SW1;
        end
      end
      ST_SW1: begin
        push = 1'b1;
        push_data = {1'b0, SW1_OK};
        if (buf_ready) begin
          next_tx_st = ST_SW2;
        end
      end
      ST_SW2: begin
        push = 1'b1;
        push_data = {1'b1, SW2_OK};
        if (buf_ready) begin
          next_tx_st = ST_IDLE;
        end
      end
      default: next_tx_st = ST_IDLE;
    endcase
    if (activate_i) begin
      next_tx_st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st <= ST_IDLE;
    end else begin
      tx_st <= next_tx_st;
    end
  end

  tab_buf2 u_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push),
    .in_ready_o(buf_ready),
    .in_data_i(push_data),
    .out_valid_o(buf_valid),
    .out_ready_i(tx_ready_i),
    .out_data_o(buf_data)
  );

  assign cmd_valid_o = cmd_valid;
  assign cmd_code_o = cmd_code;
  assign cmd_p1_o = p1;
  assign cmd_p2_o = p2;
  assign cmd_lc_o = lc;
  assign cmd_le_o = le;
  assign deselect_o = desel;
  assign block_num_o = bn;
  assign tx_valid_o = buf_valid;
  assign tx_data_o = buf_data[7:0];
  assign tx_last_o = buf_data[8];
endmodule : tab_proto
`default_nettype wire

// File: tab_pkg.sv
// Purpose: Shared constants for the tag block protocol handler
// Assumes: Byte-wide frame stream with start and end markers
// Notes: Block codes follow the protocol control byte layout
package tab_pkg;
  localparam logic [7:0] CLA_STD = 8'h00;
  localparam logic [7:0] CLA_PROP = 8'ha2;
  localparam logic [7:0] INS_SELECT = 8'ha4;
  localparam logic [7:0] INS_READ = 8'hb0;
  localparam logic [7:0] INS_UPDATE = 8'hd6;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_CHG_REF = 8'h24;
  localparam logic [7:0] INS_EN_VER = 8'h28;
  localparam logic [7:0] INS_DIS_VER = 8'h26;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY_REF = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [7:0] I_MASK = 8'hf6;
  localparam logic [7:0] I_VAL = 8'h02;
  localparam logic [7:0] R_MASK = 8'he6;
  localparam logic [7:0] R_VAL = 8'ha2;
  localparam logic [7:0] S_MASK = 8'hc7;
  localparam logic [7:0] S_VAL = 8'hc2;
  localparam int PCB_BN = 0;
  localparam int PCB_DID = 3;
  localparam int PCB_ACK = 4;
  localparam int PCB_WTX = 4;
  localparam logic [7:0] MAX_PAYLOAD = 8'hfb;
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_SELECT = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_UPDATE = 4'h3;
  localparam logic [3:0] CMD_VERIFY = 4'h4;
  localparam logic [3:0] CMD_CHG_REF = 4'h5;
  localparam logic [3:0] CMD_EN_VER = 4'h6;
  localparam logic [3:0] CMD_DIS_VER = 4'h7;
  localparam logic [3:0] CMD_PERM_LOCK = 4'h8;
  localparam logic [3:0] CMD_EXT_READ = 4'h9;
  localparam logic [3:0] CMD_UNKNOWN = 4'hf;
  localparam logic [1:0] BLK_I = 2'h0;
  localparam logic [1:0] BLK_R = 2'h1;
  localparam logic [1:0] BLK_S = 2'h2;
  localparam logic [1:0] BLK_BAD = 2'h3;
endpackage : tab_pkg

// File: tab_buf2.sv
// Purpose: Two-entry valid/ready buffer for outgoing bytes
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full at two entries, ready low while full
`timescale 1ns/100ps
`default_nettype none
module tab_buf2 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [8:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [8:0] out_data_o
);
  logic [8:0] head;
  logic [8:0] next_head;
  logic [8:0] spare;
  logic [8:0] next_spare;
  logic head_valid;
  logic next_head_valid;
  logic spare_valid;
  logic next_spare_valid;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid_i && !spare_valid;
    pop = head_valid && out_ready_i;
    next_head = head;
    next_spare = spare;
    next_head_valid = head_valid;
    next_spare_valid = spare_valid;
    // Spare moves up behind a taken byte
    if (pop) begin
      next_head = spare;
      next_head_valid = spare_valid;
      next_spare_valid = 1'b0;
    end
    // Front slot filled first, order kept
    if (push) begin
      if (!next_head_valid) begin
        next_head = in_data_i;
        next_head_valid = 1'b1;
      end else begin
        next_spare = in_data_i;
        next_spare_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head <= 9'h000;
      spare <= 9'h000;
      head_valid <= 1'b0;
      spare_valid <= 1'b0;
    end else begin
      head <= next_head;
      spare <= next_spare;
      head_valid <= next_head_valid;
      spare_valid <= next_spare_valid;
    end
  end

  // Drain side straight from flops
  assign in_ready_o = !spare_valid;
  assign out_valid_o = head_valid;
  assign out_data_o = head;
endmodule : tab_buf2
`default_nettype wire

// File: tab_proto_monitor.sv
// Purpose: Port checks for tab_proto
// Assumes: One clock domain
// Notes: Bound into every tab_proto
`timescale 1ns/100ps
`default_nettype none
module tab_proto_monitor import tab_pkg::*; (
  // Watched ports
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic activate_i,
  input wire logic rx_valid_i,
  input wire logic rx_eof_i,
  input wire logic cmd_valid_o,
  input wire logic deselect_o,
  input wire logic block_num_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_frame_end;
    $past(rx_eof_i) && !$past(rx_valid_i);
  endsequence
  sequence s_resp_pcb;
    ##[1:8] (tx_valid_o && tx_data_o == (I_VAL | {7'h00, block_num_o}));
  endsequence
  chk_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("cmd pulse too long");
  chk_cmd_cause: assert property (cmd_valid_o |-> s_frame_end)
    else $error("cmd without frame end");
  chk_bn_toggle: assert property (cmd_valid_o |-> block_num_o != $past(block_num_o))
    else $error("block number kept");
  chk_bn_cause: assert property ($changed(block_num_o) |-> $past(rx_eof_i) || $past(activate_i))
    else $error("block number moved alone");
  chk_resp_pcb: assert property (cmd_valid_o |-> s_resp_pcb)
    else $error("response header missing");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i && !activate_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("stalled byte lost");
  chk_last_sw2: assert property (tx_valid_o && tx_last_o |-> tx_data_o == SW2_OK)
    else $error("last byte not status");
  chk_des_pulse: assert property (deselect_o |-> s_frame_end ##1 !deselect_o)
    else $error("deselect pulse bad");
endmodule : tab_proto_monitor
bind tab_proto tab_proto_monitor u_mon (.clk_i, .arst_n_i, .activate_i, .rx_valid_i,
  .rx_eof_i, .cmd_valid_o, .deselect_o, .block_num_o, .tx_valid_o, .tx_ready_i,
  .tx_data_o, .tx_last_o);
`default_nettype wire

// File: tab_reader_model.sv
// Purpose: Reader model sending frames and taking responses
// Assumes: Bytes framed with start and end markers
// Notes: Stalls the response on every other cycle when slow
`timescale 1ns/100ps
`default_nettype none
module tab_reader_model import tab_pkg::*; (
  // Clock and stall control
  input wire logic clk_i,
  input wire logic slow_i,
  // Frame bytes toward the tag
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_sof_o,
  output logic rx_eof_o,
  // Response bytes from the tag
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [8:0] got[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_sof_o = 1'b0;
    rx_eof_o = 1'b0;
  end
  always @(negedge clk_i) tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  always @(posedge clk_i) if (tx_valid_i && tx_ready_o) got.push_back({tx_last_i, tx_data_i});
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY_REF) : (r >> 1);
    return r;
  endfunction : crc_upd
  task automatic put(input logic [7:0] b, input logic s);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
    rx_sof_o = s;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
    rx_sof_o = 1'b0;
  endtask : put
  task automatic send(input logic [7:0] f [8], input int n, input logic bad);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      put(f[i], i == 0);
      c = crc_upd(c, f[i]);
    end
    put(c[7:0] ^ {7'h00, bad}, 1'b0);
    put(c[15:8], 1'b0);
    @(negedge clk_i);
    rx_eof_o = 1'b1;
    @(negedge clk_i);
    rx_eof_o = 1'b0;
  endtask : send
endmodule : tab_reader_model
`default_nettype wire

// File: tag_apdu_block_protocol_test.sv
// Purpose: Self-checking bench for tab_proto
// Assumes: Reader model on the frame side
// Notes: Tag number tracked in tbn
`timescale 1ns/100ps
`default_nettype none
module tag_apdu_block_protocol_test;
  import tab_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic act = 1'b0;
  logic slow = 1'b0;
  // reader starts at 0, tag at 1
  logic tbn = 1'b1;
  logic rxv, rxs, rxe, cv, des, bn, txv, txr, txl;
  logic [7:0] rxd, p1, p2, lc, le, txd;
  logic [3:0] code;
  logic [7:0] f [8];
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int n_cmd = 0;
  int n_des = 0;
  always #4 clk = ~clk;
  tab_proto dut (.clk_i(clk), .arst_n_i(arst_n), .activate_i(act), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_sof_i(rxs), .rx_eof_i(rxe), .cmd_valid_o(cv), .cmd_code_o(code),
    .cmd_p1_o(p1), .cmd_p2_o(p2), .cmd_lc_o(lc), .cmd_le_o(le), .deselect_o(des),
    .block_num_o(bn), .tx_valid_o(txv), .tx_ready_i(txr), .tx_data_o(txd), .tx_last_o(txl));
  tab_reader_model m (.clk_i(clk), .slow_i(slow), .rx_valid_o(rxv), .rx_data_o(rxd),
    .rx_sof_o(rxs), .rx_eof_o(rxe), .tx_valid_i(txv), .tx_data_i(txd), .tx_last_i(txl),
    .tx_ready_o(txr));
  task final_report;
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_cmd <= n_cmd + int'(cv === 1'b1);
    n_des <= n_des + int'(des === 1'b1);
    if (cycles == 6000) begin
      error_cnt++;
      final_report();
    end
  end
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task xchg(input logic [7:0] cla, input logic [7:0] ins, input logic [3:0] exp);
    int c0;
    c0 = n_cmd;
    // reader number is the tag's inverse
    f = '{I_VAL | {7'h00, ~tbn}, cla, ins, 8'h11, 8'h22, 8'h01, 8'h5a, ins ^ 8'h0f};
    m.send(f, 8, 1'b0);
    tbn = ~tbn;
    repeat (2) @(negedge clk);
    check("cmd count", 16'(n_cmd - c0), 16'h0001);
    check("code", {12'h000, code}, {12'h000, exp});
    check("p1 p2 lc le", {p1, p2} ^ {lc, le}, {8'h10, 8'h22 ^ ins ^ 8'h0f});
    check("block number", {15'h0000, bn}, {15'h0000, tbn});
    for (int k = 0; k < 60 && m.got.size() < 3; k++) @(negedge clk);
    check("resp size", 16'(m.got.size()), 16'h0003);
    check("resp pcb", {7'h00, m.got[0]}, {8'h00, I_VAL | {7'h00, tbn}});
    check("sw1 sw2", {m.got[1][7:0], m.got[2][7:0]}, {SW1_OK, SW2_OK});
    check("last flags", {14'h0000, m.got[1][8], m.got[2][8]}, 16'h0001);
    m.got.delete();
  endtask : xchg
  task t_decode;
    xchg(CLA_STD, INS_SELECT, CMD_SELECT);
    xchg(CLA_STD, INS_READ, CMD_READ);
    slow = 1'b1;
    xchg(CLA_STD, INS_UPDATE, CMD_UPDATE);
    xchg(CLA_STD, INS_VERIFY, CMD_VERIFY);
    xchg(CLA_STD, INS_CHG_REF, CMD_CHG_REF);
    xchg(CLA_STD, INS_EN_VER, CMD_EN_VER);
    slow = 1'b0;
    xchg(CLA_STD, INS_DIS_VER, CMD_DIS_VER);
    xchg(CLA_PROP, INS_EN_VER, CMD_PERM_LOCK);
    xchg(CLA_PROP, INS_READ, CMD_EXT_READ);
    xchg(CLA_STD, 8'h77, CMD_UNKNOWN);
    xchg(8'h55, INS_SELECT, CMD_UNKNOWN);
  endtask : t_decode
  task t_restart;
    @(negedge clk);
    act = 1'b1;
    @(negedge clk);
    act = 1'b0;
    tbn = 1'b1;
    @(negedge clk);
    check("bn activate", {15'h0000, bn}, 16'h0001);
    xchg(CLA_STD, INS_SELECT, CMD_SELECT);
  endtask : t_restart
  task send_chk(input logic [7:0] pcb, input int n, input logic bad, input int dc, input int dd);
    int c0;
    int d0;
    c0 = n_cmd;
    d0 = n_des;
    f[0] = pcb;
    m.send(f, n, bad);
    repeat (2) @(negedge clk);
    check("cmd count", 16'(n_cmd - c0), 16'(dc));
    check("deselects", 16'(n_des - d0), 16'(dd));
    check("block number", {15'h0000, bn}, {15'h0000, tbn});
    repeat (6) @(negedge clk);
    check("no answer", 16'(m.got.size()), 16'h0000);
  endtask : send_chk
  task t_reject;
    send_chk(I_VAL | {7'h00, ~tbn}, 8, 1'b1, 0, 0);
    send_chk(I_VAL | {7'h00, tbn}, 8, 1'b0, 0, 0);
    send_chk(8'h22 | {7'h00, ~tbn}, 8, 1'b0, 0, 0);
  endtask : t_reject
  task t_rblocks;
    send_chk(8'hb2 | {7'h00, ~tbn}, 1, 1'b0, 0, 0);
    send_chk(R_VAL | {7'h00, tbn}, 1, 1'b0, 0, 0);
    tbn = ~tbn;
    send_chk(R_VAL | {7'h00, tbn}, 1, 1'b0, 0, 0);
    send_chk(S_VAL, 1, 1'b0, 0, 1);
    send_chk(8'hf2, 2, 1'b0, 0, 0);
    tbn = ~tbn;
    send_chk(8'haa | {7'h00, tbn}, 2, 1'b0, 0, 0);
  endtask : t_rblocks
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    check("bn reset", {15'h0000, bn}, 16'h0001);
    t_decode();
    t_restart();
    t_reject();
    t_rblocks();
    final_report();
  end
endmodule : tag_apdu_block_protocol_test
`default_nettype wire
